/* shared/pwr_irq_map.svh */
`ifndef PWR_IRQ_MAP_SVH
`define PWR_IRQ_MAP_SVH
// ---------------------------------------------
// register indices, byte address is four times the index
// ---------------------------------------------
`define IRQ_REQ_IDX    8'hC8
`define IRQ_EN_IDX     8'hC9
`define OSC_CTL_IDX    8'hCA
`define STACK_PTR_IDX  8'hDF
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define PIN_IRQ_BIT    0
`define TIMER_IRQ_BIT  4
`define HOSC_STOP_BIT  1
`define SLOW_SEL_BIT   2
`define SLEEP_SEL_BIT  3
`define GLB_EN_BIT     7
// ---------------------------------------------
// reset values and counts
// ---------------------------------------------
`define STACK_RST      3'h7
`define IRQ_VECTOR     12'h008
`define WAKE_CLKS      2048
`define DIV_SLOW       4
`define DIV_XTAL       4
`define DIV_RC         16
`endif

/* shared/pwr_irq_pkg.sv */
package pwr_irq_pkg;
   // ---------------------------------------------
   // operating states
   // ---------------------------------------------
   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_WAKE  = 2'b10
   } mode_e;
   // ---------------------------------------------
   // carriers
   // ---------------------------------------------
   typedef struct packed {
      logic hoscEn;
      logic loscEn;
      logic slowSel;
      logic cpuRun;
   } clk_ctl_s;
   typedef struct packed {
      logic        take;
      logic        pop;
      logic [11:0] vector;
   } irq_evt_s;
endpackage : pwr_irq_pkg

/* rtl/cycle_divider.sv */
`timescale 1ns/10ps
module cycle_divider #(
   parameter int CNT_W = 4
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // source tick and ratio
   input  wire logic             srcTick,
   input  wire logic [CNT_W-1:0] lastCount,
   // instruction cycle pulse
   output logic                  cycleTick
);
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q     <= '0;
         cycleTick <= 1'b0;
      end else begin
         cycleTick <= srcTick && (cnt_q >= lastCount);
         if (srcTick) begin
            cnt_q <= (cnt_q >= lastCount) ? '0 : cnt_q + 1'b1;
         end
      end
   end
endmodule : cycle_divider

/* rtl/power_mode_and_interrupt_ctrl.sv */
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
`include "pwr_irq_map.svh"
module power_mode_and_interrupt_ctrl #(
   parameter int ADR_W     = 10,
   parameter int WAKE_W    = 16,
   parameter int WAKE_CLKS = `WAKE_CLKS
) (
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // wishbone slave
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [ADR_W-1:0]       adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [31:0]            dat_i,
   output logic [31:0]                 dat_o,
   output logic                        ack_o,
   // oscillator ticks and options
   input  wire logic                   hoscTick,
   input  wire logic                   loscTick,
   input  wire logic                   highClkIsRc,
   input  wire logic                   watchdogOn,
   input  wire logic                   greenMode,
   // wakeup pins and events
   input  wire logic [WAKE_W-1:0]      wakePins,
   input  wire logic                   pinIrqEvent,
   input  wire logic                   timerOverflow,
   // processor handshake
   input  wire logic                   instrBoundary,
   input  wire logic                   returnExec,
   // status and control outputs
   output pwr_irq_pkg::clk_ctl_s       clkCtl,
   output pwr_irq_pkg::irq_evt_s       irqEvt,
   output pwr_irq_pkg::mode_e          mode,
   output logic                        cpuCycle
);
   localparam logic [11:0] WAKE_LAST = 12'(WAKE_CLKS - 1);

   function automatic logic [3:0] lastOf(input int div);
      lastOf = 4'(div - 1);
   endfunction : lastOf

   function automatic logic [7:0] packPair(input logic hi, input logic lo);
      packPair = {3'h0, hi, 3'h0, lo};
   endfunction : packPair

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   pwr_irq_pkg::mode_e    mode_q, mode_d;
   pwr_irq_pkg::clk_ctl_s clkCtl_q, clkCtl_d;
   pwr_irq_pkg::irq_evt_s irqEvt_q;
   logic                  oscStop_q, slowSel_q, sleepSel_q;
   logic                  pinEn_q, timerEn_q, pinFlag_q, timerFlag_q;
   logic                  glbEn_q;
   logic [2:0]            stack_q;
   logic [11:0]           wakeCnt_q;
   logic [WAKE_W-1:0]     wakeSync1_q, wakeSync2_q, wakeLast_q;
   logic                  ack_q;
   logic [7:0]            datOut_q;

   // ---------------------------------------------
   // bus decode
   // ---------------------------------------------
   wire [7:0] regIdx  = adr_i[9:2];
   wire       busReq  = cyc_i && stb_i;
   wire       hitReq  = regIdx == `IRQ_REQ_IDX;
   wire       hitEn   = regIdx == `IRQ_EN_IDX;
   wire       hitOsc  = regIdx == `OSC_CTL_IDX;
   wire       hitStk  = regIdx == `STACK_PTR_IDX;
   wire       wrLane  = busReq && we_i && ack_q && sel_i[0];
   wire       wrReq   = wrLane && hitReq;
   wire       wrEn    = wrLane && hitEn;
   wire       wrOsc   = wrLane && hitOsc;
   wire       wrStk   = wrLane && hitStk;
   wire [7:0] reqByte = packPair(timerFlag_q, pinFlag_q);
   wire [7:0] enByte  = packPair(timerEn_q, pinEn_q);
   wire [7:0] oscByte = {4'h0, sleepSel_q, slowSel_q, oscStop_q, 1'b0};
   wire [7:0] stkByte = {glbEn_q, 4'h0, stack_q};
   wire [7:0] rdByte  = hitReq ? reqByte :
                        hitEn  ? enByte  :
                        hitOsc ? oscByte :
                        hitStk ? stkByte : 8'h00;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_q    <= 1'b0;
         datOut_q <= 8'h00;
      end else begin
         ack_q    <= busReq && !ack_q;
         datOut_q <= (busReq && !ack_q) ? rdByte : datOut_q;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = {24'h000000, datOut_q};

   // ---------------------------------------------
   // wake pin synchroniser
   // ---------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         wakeSync1_q <= '0;
         wakeSync2_q <= '0;
         wakeLast_q  <= '0;
      end else begin
         wakeSync1_q <= wakePins;
         wakeSync2_q <= wakeSync1_q;
         wakeLast_q  <= wakeSync2_q;
      end
   end

   wire wakeChange = |(wakeSync2_q ^ wakeLast_q);

   // ---------------------------------------------
   // operating mode
   // ---------------------------------------------
   wire wakeDone = (mode_q == pwr_irq_pkg::MODE_WAKE) && hoscTick && (wakeCnt_q == WAKE_LAST);

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         pwr_irq_pkg::MODE_RUN: begin
            if (sleepSel_q) begin
               mode_d = pwr_irq_pkg::MODE_SLEEP;
            end
         end
         pwr_irq_pkg::MODE_SLEEP: begin
            if (wakeChange) begin
               mode_d = pwr_irq_pkg::MODE_WAKE;
            end
         end
         pwr_irq_pkg::MODE_WAKE: begin
            if (wakeDone) begin
               mode_d = pwr_irq_pkg::MODE_RUN;
            end
         end
         default: mode_d = pwr_irq_pkg::MODE_RUN;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_q    <= pwr_irq_pkg::MODE_RUN;
         wakeCnt_q <= 12'h000;
      end else begin
         mode_q    <= mode_d;
         wakeCnt_q <= (mode_q != pwr_irq_pkg::MODE_WAKE) ? 12'h000 :
                      hoscTick ? wakeCnt_q + 12'h001 : wakeCnt_q;
      end
   end

   // ---------------------------------------------
   // oscillator control register
   // ---------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         oscStop_q  <= 1'b0;
         slowSel_q  <= 1'b0;
         sleepSel_q <= 1'b0;
      end else if (wakeDone) begin
         oscStop_q  <= 1'b0;
         slowSel_q  <= 1'b0;
         sleepSel_q <= 1'b0;
      end else if (wrOsc) begin
         oscStop_q  <= dat_i[`HOSC_STOP_BIT];
         slowSel_q  <= dat_i[`SLOW_SEL_BIT];
         sleepSel_q <= dat_i[`SLEEP_SEL_BIT];
      end
   end

   // ---------------------------------------------
   // clock gating
   // ---------------------------------------------
   wire inRun   = mode_q == pwr_irq_pkg::MODE_RUN;
   wire inSleep = mode_q == pwr_irq_pkg::MODE_SLEEP;

   always_comb begin
      clkCtl_d.hoscEn  = !inSleep && !(oscStop_q && slowSel_q && inRun);
      clkCtl_d.loscEn  = !inSleep && !(greenMode && !watchdogOn);
      clkCtl_d.slowSel = slowSel_q && inRun;
      clkCtl_d.cpuRun  = inRun && !sleepSel_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         clkCtl_q <= '{hoscEn: 1'b1, loscEn: 1'b1, slowSel: 1'b0, cpuRun: 1'b1};
      end else begin
         clkCtl_q <= clkCtl_d;
      end
   end

   assign clkCtl = clkCtl_q;
   assign mode   = mode_q;

   // ---------------------------------------------
   // instruction cycle
   // ---------------------------------------------
   wire       srcTick = clkCtl_q.cpuRun && (clkCtl_q.slowSel ? (loscTick && clkCtl_q.loscEn)
                                                             : (hoscTick && clkCtl_q.hoscEn));
   wire [3:0] divLast = clkCtl_q.slowSel ? lastOf(`DIV_SLOW) :
                        highClkIsRc      ? lastOf(`DIV_RC)   :
                                           lastOf(`DIV_XTAL);

   cycle_divider #(
      .CNT_W     (4)
   ) u_div (
      .mclk      (mclk),
      .rst       (rst),
      .srcTick   (srcTick),
      .lastCount (divLast),
      .cycleTick (cpuCycle)
   );

   // ---------------------------------------------
   // interrupt enables and flags
   // ---------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinEn_q   <= 1'b0;
         timerEn_q <= 1'b0;
      end else if (wrEn) begin
         pinEn_q   <= dat_i[`PIN_IRQ_BIT];
         timerEn_q <= dat_i[`TIMER_IRQ_BIT];
      end
   end
   // event wins over a clearing write in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinFlag_q   <= 1'b0;
         timerFlag_q <= 1'b0;
      end else begin
         pinFlag_q   <= pinIrqEvent || (wrReq ? dat_i[`PIN_IRQ_BIT] : pinFlag_q);
         timerFlag_q <= timerOverflow || (wrReq ? dat_i[`TIMER_IRQ_BIT] : timerFlag_q);
      end
   end

   // ---------------------------------------------
   // interrupt entry and return
   // ---------------------------------------------
   wire pending = (pinFlag_q && pinEn_q) || (timerFlag_q && timerEn_q);
   wire takeNow = glbEn_q && pending && instrBoundary && clkCtl_q.cpuRun && !irqEvt_q.take;
   wire popNow  = returnExec && !takeNow;

   always_ff @(posedge mclk) begin
      if (rst) begin
         glbEn_q <= 1'b0;
         stack_q <= `STACK_RST;
      end else if (takeNow) begin
         glbEn_q <= 1'b0;
         stack_q <= stack_q - 3'h1;
      end else if (popNow) begin
         glbEn_q <= 1'b1;
         stack_q <= stack_q + 3'h1;
      end else if (wrStk) begin
         glbEn_q <= dat_i[`GLB_EN_BIT];
         stack_q <= dat_i[2:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irqEvt_q <= '{take: 1'b0, pop: 1'b0, vector: `IRQ_VECTOR};
      end else begin
         irqEvt_q.take   <= takeNow;
         irqEvt_q.pop    <= popNow;
         irqEvt_q.vector <= `IRQ_VECTOR;
      end
   end

   assign irqEvt = irqEvt_q;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_slow_div;
      clkCtl_q.slowSel |-> divLast == 4'h3;
   endproperty
   a_slow_div: assert property (p_slow_div) else $error("slow ratio not four");

   property p_rc_div;
      !clkCtl_q.slowSel && highClkIsRc |-> divLast == 4'hF;
   endproperty
   a_rc_div: assert property (p_rc_div) else $error("rc ratio not sixteen");

   property p_losc_stop;
      !clkCtl_q.loscEn |-> $past(inSleep) || ($past(greenMode) && !$past(watchdogOn));
   endproperty
   a_losc_stop: assert property (p_losc_stop) else $error("low osc stopped without cause");

   property p_sleep_stops;
      inSleep [*2] |-> !clkCtl_q.hoscEn && !clkCtl_q.loscEn && !clkCtl_q.cpuRun;
   endproperty
   a_sleep_stops: assert property (p_sleep_stops) else $error("clock left on in sleep");

   property p_hosc_stop;
      oscStop_q && slowSel_q && inRun |=>
         !clkCtl_q.hoscEn && (clkCtl_q.loscEn || ($past(greenMode) && !$past(watchdogOn)));
   endproperty
   a_hosc_stop: assert property (p_hosc_stop) else $error("fast osc not halted");

   property p_sleep_entry;
      sleepSel_q && inRun |=> inSleep;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

   property p_sleep_hold;
      inSleep && !wakeChange |=> inSleep;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without pin change");

   property p_wake_count;
      inRun && $past(mode_q) == pwr_irq_pkg::MODE_WAKE |->
         $past(wakeCnt_q) == WAKE_LAST && !sleepSel_q && !slowSel_q;
   endproperty
   a_wake_count: assert property (p_wake_count) else $error("wake time not counted");

   property p_take;
      irqEvt_q.take |-> !glbEn_q && stack_q == $past(stack_q) - 3'h1 && irqEvt_q.vector == 12'h008;
   endproperty
   a_take: assert property (p_take) else $error("interrupt entry wrong");

   property p_take_cause;
      irqEvt_q.take |-> $past(glbEn_q) && $past(pending);
   endproperty
   a_take_cause: assert property (p_take_cause) else $error("vector without enable");

   property p_return;
      irqEvt_q.pop |-> glbEn_q && stack_q == $past(stack_q) + 3'h1;
   endproperty
   a_return: assert property (p_return) else $error("return did not restore");

   property p_flag_set;
      pinIrqEvent && !pinEn_q |=> pinFlag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   c_sleep_wake: cover property (inSleep ##1 mode_q == pwr_irq_pkg::MODE_WAKE);
   c_take:       cover property (irqEvt_q.take);
   c_return:     cover property (irqEvt_q.pop);
   c_slow_stop:  cover property (clkCtl_q.slowSel && !clkCtl_q.hoscEn);
endmodule : power_mode_and_interrupt_ctrl

/* sim/osc_tick_model.sv */
`timescale 1ns/10ps
module osc_tick_model (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // oscillator enables from the block
   input  wire logic hoscEn,
   input  wire logic loscEn,
   // oscillator tick pulses
   output logic      hoscTick = 1'b0,
   output logic      loscTick = 1'b0
);
   // ----------
   // free-running phase, ticks only while enabled
   // ----------
   logic [3:0] phase_q = 4'h0;
   always @(posedge mclk) begin
      if (rst) begin
         phase_q  <= 4'h0;
         hoscTick <= 1'b0;
         loscTick <= 1'b0;
      end else begin
         phase_q  <= (phase_q == 4'hE) ? 4'h0 : phase_q + 4'h1;
         hoscTick <= hoscEn && (phase_q % 4'h3 == 4'h0);
         loscTick <= loscEn && (phase_q % 4'h5 == 4'h0);
      end
   end
endmodule : osc_tick_model

/* sim/test_power_mode_and_interrupt_ctrl.sv */
`timescale 1ns/10ps
module test_power_mode_and_interrupt_ctrl;
   // ----------
   // signals
   // ----------
   localparam int WK = 8;
   logic                  mclk = 1'b0;
   logic                  rst = 1'b1;
   logic                  cyc = 1'b0;
   logic                  stb = 1'b0;
   logic                  we = 1'b0;
   logic [9:0]            adr = 10'h000;
   logic [3:0]            sel = 4'h0;
   logic [31:0]           wdat = 32'h0;
   logic [31:0]           rdat;
   logic                  ack;
   logic                  hoscTick;
   logic                  loscTick;
   logic                  highClkIsRc = 1'b0;
   logic                  watchdogOn = 1'b1;
   logic                  greenMode = 1'b0;
   logic [15:0]           wakePins = 16'h0000;
   logic                  pinIrqEvent = 1'b0;
   logic                  timerOverflow = 1'b0;
   logic                  instrBoundary = 1'b0;
   logic                  returnExec = 1'b0;
   pwr_irq_pkg::clk_ctl_s clkCtl;
   pwr_irq_pkg::irq_evt_s irqEvt;
   pwr_irq_pkg::mode_e    mode;
   logic                  cpuCycle;
   logic [31:0]           seed = 32'h0000004B;
   logic [31:0]           v;
   int                    error_cnt = 0;
   int                    check_count = 0;
   int                    takeCnt = 0;
   int                    popCnt = 0;
   int                    c;
   int                    i;

   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      takeCnt += (irqEvt.take === 1'b1);
      popCnt  += (irqEvt.pop === 1'b1);
   end

   power_mode_and_interrupt_ctrl #(.WAKE_CLKS(WK)) u_power_mode_and_interrupt_ctrl (
      .mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .hoscTick(hoscTick), .loscTick(loscTick),
      .highClkIsRc(highClkIsRc), .watchdogOn(watchdogOn), .greenMode(greenMode), .wakePins(wakePins),
      .pinIrqEvent(pinIrqEvent), .timerOverflow(timerOverflow), .instrBoundary(instrBoundary),
      .returnExec(returnExec), .clkCtl(clkCtl), .irqEvt(irqEvt), .mode(mode), .cpuCycle(cpuCycle));
   osc_tick_model u_osc_tick_model (.mclk(mclk), .rst(rst), .hoscEn(clkCtl.hoscEn),
      .loscEn(clkCtl.loscEn), .hoscTick(hoscTick), .loscTick(loscTick));

   // ----------
   // helpers
   // ----------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask : chk

   task automatic hang(input string what);
      chk(what, 32'h1, 32'h0);
      close_out();
   endtask : hang

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      sel  <= 4'h1;
      wdat <= {24'h0, d};
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge mclk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n == 20) hang("bus ack");
   endtask : wb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, idx, d, q);
   endtask : wr

   task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk(what, exp, q);
   endtask : rdChk

   task automatic pulse(input logic [2:0] m);
      @(posedge mclk);
      {pinIrqEvent, timerOverflow, returnExec} <= m;
      @(posedge mclk);
      {pinIrqEvent, timerOverflow, returnExec} <= 3'b000;
   endtask : pulse

   task automatic waitMode(input pwr_irq_pkg::mode_e m);
      int n;
      for (n = 0; n < 20 && mode !== m; n++) @(posedge mclk);
      if (n == 20) hang("mode");
   endtask : waitMode

   task automatic cycleRatio(input logic useLow, output int cnt);
      int n;
      cnt = 0;
      n = 0;
      do @(negedge mclk); while (cpuCycle !== 1'b1 && ++n < 300);
      do begin
         cnt += ((useLow ? loscTick : hoscTick) === 1'b1);
         @(negedge mclk);
      end while (cpuCycle !== 1'b1 && ++n < 600);
      @(posedge mclk);
      if (n >= 600) hang("cpu cycle");
   endtask : cycleRatio

   // ----------
   // main sequence
   // ----------
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("clock control", 32'hD, clkCtl);
      rdChk(8'hC8, 32'h0, "flags");
      rdChk(8'hC9, 32'h0, "enables");
      rdChk(8'hCA, 32'h0, "osc control");
      rdChk(8'hDF, 32'h7, "stack");
      wr(8'h40, 8'hFF);
      rdChk(8'h40, 32'h0, "unmapped");
      for (i = 0; i < 4; i++) begin
         v = xs();
         wr(8'hC9, v[7:0]);
         rdChk(8'hC9, {24'h0, v[7:0] & 8'h11}, "enables");
      end
      wr(8'hC9, 8'h11);
      instrBoundary <= 1'b1;
      pulse(3'b110);
      rdChk(8'hC8, 32'h11, "flags");
      chk("takes", 32'h0, takeCnt);
      wr(8'hC8, 8'h00);
      rdChk(8'hC8, 32'h0, "flags");
      wr(8'hC9, 8'h00);
      wr(8'hDF, 8'h87);
      pulse(3'b010);
      chk("takes", 32'h0, takeCnt);
      wr(8'hC9, 8'h10);
      for (i = 0; i < 20 && takeCnt == 0; i++) @(posedge mclk);
      if (takeCnt == 0) hang("take");
      chk("vector", 32'h8, irqEvt.vector);
      rdChk(8'hDF, 32'h6, "stack");
      wr(8'hC8, 8'h00);
      pulse(3'b001);
      repeat (2) @(posedge mclk);
      chk("pops", 32'h1, popCnt);
      chk("takes", 32'h1, takeCnt);
      rdChk(8'hDF, 32'h87, "stack");
      wr(8'hC9, 8'h00);
      wr(8'hCA, 8'h04);
      repeat (3) @(posedge mclk);
      chk("slow select", 32'h1, clkCtl.slowSel);
      cycleRatio(1'b1, c);
      cycleRatio(1'b1, c);
      chk("slow ratio", 32'd4, c);
      wr(8'hCA, 8'h06);
      repeat (3) @(posedge mclk);
      chk("high stopped", 32'h3, {clkCtl.hoscEn, clkCtl.loscEn, clkCtl.slowSel});
      greenMode  <= 1'b1;
      watchdogOn <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("low in green", 32'h0, clkCtl.loscEn);
      greenMode <= 1'b0;
      wr(8'hCA, 8'h04);
      repeat (50) @(posedge mclk);
      wr(8'hCA, 8'h00);
      for (i = 0; i < 2; i++) begin
         highClkIsRc <= i[0];
         cycleRatio(1'b0, c);
         cycleRatio(1'b0, c);
         chk("normal ratio", i ? 32'd16 : 32'd4, c);
      end
      v = xs();
      wakePins <= v[15:0];
      wr(8'hCA, 8'h0C);
      waitMode(pwr_irq_pkg::MODE_SLEEP);
      repeat (3) @(posedge mclk);
      chk("sleep clocks", 32'h0, clkCtl);
      pulse(3'b110);
      repeat (20) @(posedge mclk);
      chk("no wake", pwr_irq_pkg::MODE_SLEEP, mode);
      v = xs();
      wakePins <= wakePins ^ (16'h1 << v[3:0]);
      waitMode(pwr_irq_pkg::MODE_WAKE);
      c = 0;
      for (i = 0; i < 200 && mode === pwr_irq_pkg::MODE_WAKE; i++) begin
         c += (hoscTick === 1'b1);
         @(posedge mclk);
      end
      chk("wake ticks", WK, c);
      chk("woken mode", pwr_irq_pkg::MODE_RUN, mode);
      rdChk(8'hCA, 32'h0, "osc control");
      close_out();
   end
endmodule : test_power_mode_and_interrupt_ctrl
